// *** dv/gpr_pin_env.sv ***
// gpr_pin_env: board around the port pins, pull-ups plus an optional external driver on port A
`timescale 1ns/1ps
module gpr_pin_env (
  input  wire logic [7:0]  pa_out,
  input  wire logic [7:0]  pa_oe,
  input  wire logic [15:0] pb_out,
  input  wire logic [15:0] pb_oe,
  input  wire logic [7:0]  pa_ext,
  input  wire logic        ext_en,
  output logic      [7:0]  pa_in,
  output logic      [15:0] pb_in
);
  // a released pin goes to its pull-up, or on port A to pa_ext while ext_en is set, so without ext_en an open-drain high reads back as one
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & (ext_en ? pa_ext : 8'hff));
  assign pb_in = (pb_oe & pb_out) | ~pb_oe;
endmodule

// *** dv/tb_gpr_top.sv ***
// tb_gpr_top: register map, reset values, pin drive and pin sampling on 28 and 14 pin builds, register reads and the SPI disable outputs on the 20 pin build
`timescale 1ns/1ps
module tb_gpr_top;
  import gpr_pkg::*;
  logic        clk, srst, wr_en, rd_en, fuse, ext_en;
  logic [15:0] addr, wr_data, rd_big, rd_sml, pb_in_b, pb_out_b, pb_oe_b, pb_in_s, pb_out_s, pb_oe_s;
  logic [7:0]  pa_in_b, pa_out_b, pa_oe_b, pa_in_s, pa_out_s, pa_oe_s, pa_ext;
  logic [15:0] rd_mid, pb_in_m, pb_out_m, pb_oe_m;
  logic [7:0]  pa_in_m, pa_out_m, pa_oe_m;
  logic [3:0]  spi_b, spi_s, spi_m;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;

  gpr_top i_gpr_top (
    .addr(addr), .clk(clk), .srst(srst), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_big),
    .reset_pin_enable_fuse(fuse), .pa_in(pa_in_b), .pa_out(pa_out_b), .pa_oe(pa_oe_b), .pb_in(pb_in_b),
    .pb_out(pb_out_b), .pb_oe(pb_oe_b), .spi1_clock_out_disable(spi_b[0]), .spi1_data_out_disable(spi_b[1]),
    .spi2_clock_out_disable(spi_b[2]), .spi2_data_out_disable(spi_b[3]));
  gpr_top #(.VARIANT(GPR_PINS_14), .SPI2_PRESENT(1'b0)) i_gpr_top_14 (
    .addr(addr), .clk(clk), .srst(srst), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_sml),
    .reset_pin_enable_fuse(fuse), .pa_in(pa_in_s), .pa_out(pa_out_s), .pa_oe(pa_oe_s), .pb_in(pb_in_s),
    .pb_out(pb_out_s), .pb_oe(pb_oe_s), .spi1_clock_out_disable(spi_s[0]), .spi1_data_out_disable(spi_s[1]),
    .spi2_clock_out_disable(spi_s[2]), .spi2_data_out_disable(spi_s[3]));
  gpr_pin_env i_gpr_pin_env (.pa_out(pa_out_b), .pa_oe(pa_oe_b), .pb_out(pb_out_b), .pb_oe(pb_oe_b),
    .pa_ext(pa_ext), .ext_en(ext_en), .pa_in(pa_in_b), .pb_in(pb_in_b));
  gpr_pin_env i_gpr_pin_env_14 (.pa_out(pa_out_s), .pa_oe(pa_oe_s), .pb_out(pb_out_s), .pb_oe(pb_oe_s),
    .pa_ext(pa_ext), .ext_en(ext_en), .pa_in(pa_in_s), .pb_in(pb_in_s));
  gpr_top #(.VARIANT(GPR_PINS_20)) i_gpr_top_20 (
    .addr(addr), .clk(clk), .srst(srst), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_mid),
    .reset_pin_enable_fuse(fuse), .pa_in(pa_in_m), .pa_out(pa_out_m), .pa_oe(pa_oe_m), .pb_in(pb_in_m),
    .pb_out(pb_out_m), .pb_oe(pb_oe_m), .spi1_clock_out_disable(spi_m[0]), .spi1_data_out_disable(spi_m[1]),
    .spi2_clock_out_disable(spi_m[2]), .spi2_data_out_disable(spi_m[3]));
  gpr_pin_env i_gpr_pin_env_20 (.pa_out(pa_out_m), .pa_oe(pa_oe_m), .pb_out(pb_out_m), .pb_oe(pb_oe_m),
    .pa_ext(pa_ext), .ext_en(ext_en), .pa_in(pa_in_m), .pb_in(pb_in_m));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ceiling sits far above the roughly 150 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, cyc, 3000);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so the 28 and 14 pin builds are sampled there
  task automatic rdc(input logic [15:0] a, input logic [15:0] eb, input logic [15:0] es);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_big, eb);
    chk(rd_sml, es);
  endtask

  // write and read back to back, with no idle cycle between the strobes
  task automatic wrrd(input logic [15:0] a, input logic [15:0] d, input logic [15:0] eb, input logic [15:0] es);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_big, eb);
    chk(rd_sml, es);
  endtask

  task automatic rdm(input logic [15:0] a, input logic [15:0] em);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_mid, em);
  endtask

  task automatic t_mid_variant();
    rdm(OFS_PB_DIR, 16'hcf79);
    rdm(OFS_PA_DIR, 16'h005f);
    wr(OFS_PB_ODC, 16'hffff);
    rdm(OFS_PB_ODC, 16'hcf79);
    wr(OFS_PB_ODC, 16'h0000);
    wr(OFS_PA_PIN, 16'h00ff);
    rdc(OFS_PA_LAT, 16'h00df, 16'h005f);
    wr(OFS_PB_PIN, 16'h1234);
    rdc(OFS_PB_LAT, 16'h1234, 16'h0210);
    rdm(OFS_PB_LAT, 16'h0230);
    wr(OFS_PAD, 16'hffff);
    rdm(OFS_PAD, 16'h0f00);
    chk({12'h000, spi_m}, 16'h000f);
    $display("test mid_variant done");
  endtask

  task automatic t_reset_values();
    rdc(OFS_PA_DIR, 16'h00df, 16'h005f);
    rdc(OFS_PB_DIR, 16'hffff, 16'hc311);
    rdc(OFS_PA_ODC, 16'h0000, 16'h0000);
    rdc(OFS_PB_ODC, 16'h0000, 16'h0000);
    rdc(OFS_PAD, 16'h0000, 16'h0000);
    chk({pa_oe_b, pa_oe_s} | pb_oe_b | pb_oe_s, 16'h0000);
    chk({8'h00, spi_b, spi_s}, 16'h0000);
    $display("test reset_values done");
  endtask

  task automatic t_masks();
    wr(OFS_PA_LAT, 16'hffff);
    rdc(OFS_PA_LAT, 16'h00df, 16'h005f);
    wr(OFS_PA_ODC, 16'hffff);
    rdc(OFS_PA_ODC, 16'h00df, 16'h005f);
    wr(OFS_PB_LAT, 16'hffff);
    rdc(OFS_PB_LAT, 16'hffff, 16'hc311);
    wr(OFS_PB_ODC, 16'hffff);
    rdc(OFS_PB_ODC, 16'hffff, 16'hc311);
    wr(OFS_PAD, 16'hffff);
    rdc(OFS_PAD, 16'h0f00, 16'h0300);
    chk({8'h00, spi_b, spi_s}, 16'h00f3);
    wr(16'h02d0, 16'hffff);
    rdc(16'h02d0, 16'h0000, 16'h0000);
    rdc(16'h02c1, 16'h0000, 16'h0000);
    wr(OFS_PA_ODC, 16'h0000);
    wr(OFS_PB_ODC, 16'h0000);
    wr(OFS_PAD, 16'h0000);
    #1;
    chk({8'h00, spi_b, spi_s}, 16'h0000);
    $display("test masks done");
  endtask

  task automatic t_drive();
    wr(OFS_PB_DIR, 16'h0000);
    wr(OFS_PB_LAT, 16'ha5a5);
    wr(OFS_PA_LAT, 16'h00ff);
    wr(OFS_PA_DIR, 16'h0000);
    #1;
    chk(pb_oe_b, 16'hffff);
    chk(pb_out_b, 16'ha5a5);
    chk(pb_oe_s, 16'hc311);
    chk(pb_out_s, 16'h8101);
    chk({pa_oe_b, pa_oe_s}, 16'hdf5f);
    chk({pa_out_b, pa_out_s}, 16'hdf5f);
    repeat (4) @(posedge clk);
    rdc(OFS_PB_PIN, 16'ha5a5, 16'h8101);
    rdc(OFS_PA_PIN, 16'h00ff, 16'h007f);
    wr(OFS_PB_ODC, 16'hffff);
    #1;
    chk(pb_oe_b, 16'h5a5a);
    chk(pb_out_b, 16'h0000);
    chk(pb_oe_s, 16'h4210);
    repeat (4) @(posedge clk);
    rdc(OFS_PB_PIN, 16'ha5a5, 16'h8101);
    wr(OFS_PB_DIR, 16'hffff);
    #1;
    chk(pb_oe_b | pb_oe_s, 16'h0000);
    $display("test drive done");
  endtask

  task automatic t_fuse();
    wr(OFS_PA_DIR, 16'h00ff);
    ext_en <= 1'b1;
    pa_ext <= 8'hff;
    fuse   <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(OFS_PA_PIN, 16'h00df, 16'h005f);
    fuse <= 1'b0;
    repeat (4) @(posedge clk);
    rdc(OFS_PA_PIN, 16'h00ff, 16'h007f);
    pa_ext <= 8'h00;
    repeat (4) @(posedge clk);
    rdc(OFS_PA_PIN, 16'h0000, 16'h0000);
    $display("test fuse done");
  endtask

  task automatic t_second_reset();
    wr(OFS_PA_DIR, 16'h0000);
    wr(OFS_PB_DIR, 16'h0000);
    wr(OFS_PB_ODC, 16'hffff);
    wr(OFS_PAD, 16'hffff);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdc(OFS_PA_DIR, 16'h00df, 16'h005f);
    rdc(OFS_PB_DIR, 16'hffff, 16'hc311);
    rdc(OFS_PB_ODC, 16'h0000, 16'h0000);
    rdc(OFS_PAD, 16'h0000, 16'h0000);
    wrrd(OFS_PAD, 16'h0a00, 16'h0a00, 16'h0200);
    wrrd(OFS_PA_DIR, 16'h00ff, 16'h00df, 16'h005f);
    $display("test second_reset done");
  endtask

  initial
  begin
    srst    = 1'b1;
    addr    = 16'h0000;
    wr_data = 16'h0000;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    fuse    = 1'b0;
    ext_en  = 1'b0;
    pa_ext  = 8'h00;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_values();
    t_masks();
    t_drive();
    t_fuse();
    t_second_reset();
    t_mid_variant();
    tally_and_finish();
  end
endmodule

// *** logic/gpr_pin_sync.sv ***
// gpr_pin_sync: three-stage pin synchroniser, a change is taken once stages two and three agree
`timescale 1ns/1ps
module gpr_pin_sync #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] val_q;
  logic [WIDTH-1:0] val_d;

  // stage one feeds only stage two; the agreement check looks at stages two and three
  always_comb
  begin
    val_d = val_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        val_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      val_q <= '0;
    end
    else
    begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      val_q <= val_d;
    end
  end

  assign pin_sync = val_q;

endmodule

// *** logic/gpr_pkg.sv ***
// gpr_pkg: shared constants, types and mask functions for the general purpose port registers
package gpr_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int PA_PINS = 8;
  localparam int PB_PINS = 16;

  // register byte offsets
  localparam logic [15:0] OFS_PA_DIR = 16'h02c0;
  localparam logic [15:0] OFS_PA_PIN = 16'h02c2;
  localparam logic [15:0] OFS_PA_LAT = 16'h02c4;
  localparam logic [15:0] OFS_PA_ODC = 16'h02c6;
  localparam logic [15:0] OFS_PB_DIR = 16'h02c8;
  localparam logic [15:0] OFS_PB_PIN = 16'h02ca;
  localparam logic [15:0] OFS_PB_LAT = 16'h02cc;
  localparam logic [15:0] OFS_PB_ODC = 16'h02ce;
  localparam logic [15:0] OFS_PAD    = 16'h02fc;

  // values after reset
  localparam logic [15:0] RST_PA_DIR = 16'h00df;
  localparam logic [15:0] RST_PB_DIR = 16'hffff;
  localparam logic [15:0] RST_ODC    = 16'h0000;
  localparam logic [15:0] RST_PAD    = 16'h0000;

  // field positions and implemented-bit layouts
  localparam logic [15:0] PA_DIR_FULL      = 16'h00df;
  localparam logic [15:0] PA_PIN_FULL      = 16'h00ff;
  localparam logic [15:0] PA_BIT7          = 16'h0080;
  localparam logic [15:0] PA_RST_PIN_BIT   = 16'h0020;
  localparam logic [15:0] PB_MISSING_SMALL = 16'h3086;
  localparam logic [15:0] PB_MISSING_14    = 16'h0c68;
  localparam logic [15:0] PAD_MASK_FULL    = 16'h0f00;
  localparam logic [15:0] PAD_MASK_SMALL   = 16'h0300;
  localparam int          PAD_SCK1_POS     = 8;
  localparam int          PAD_SDO1_POS     = 9;
  localparam int          PAD_SCK2_POS     = 10;
  localparam int          PAD_SDO2_POS     = 11;

  typedef enum logic [1:0] {
    GPR_PINS_14 = 2'b00,
    GPR_PINS_20 = 2'b01,
    GPR_PINS_28 = 2'b10
  } gpr_variant_t;

  typedef enum logic [3:0] {
    GPR_SEL_NONE   = 4'b0000,
    GPR_SEL_PA_DIR = 4'b0001,
    GPR_SEL_PA_PIN = 4'b0010,
    GPR_SEL_PA_LAT = 4'b0011,
    GPR_SEL_PA_ODC = 4'b0100,
    GPR_SEL_PB_DIR = 4'b0101,
    GPR_SEL_PB_PIN = 4'b0110,
    GPR_SEL_PB_LAT = 4'b0111,
    GPR_SEL_PB_ODC = 4'b1000,
    GPR_SEL_PAD    = 4'b1001
  } gpr_reg_t;

  function automatic gpr_reg_t gpr_decode(input logic [15:0] addr);
    case (addr)
      OFS_PA_DIR: gpr_decode = GPR_SEL_PA_DIR;
      OFS_PA_PIN: gpr_decode = GPR_SEL_PA_PIN;
      OFS_PA_LAT: gpr_decode = GPR_SEL_PA_LAT;
      OFS_PA_ODC: gpr_decode = GPR_SEL_PA_ODC;
      OFS_PB_DIR: gpr_decode = GPR_SEL_PB_DIR;
      OFS_PB_PIN: gpr_decode = GPR_SEL_PB_PIN;
      OFS_PB_LAT: gpr_decode = GPR_SEL_PB_LAT;
      OFS_PB_ODC: gpr_decode = GPR_SEL_PB_ODC;
      OFS_PAD:    gpr_decode = GPR_SEL_PAD;
      default:    gpr_decode = GPR_SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] gpr_pa_dir_mask(input gpr_variant_t v);
    gpr_pa_dir_mask = (v == GPR_PINS_28) ? PA_DIR_FULL : (PA_DIR_FULL & ~PA_BIT7);
  endfunction

  function automatic logic [15:0] gpr_pa_pin_mask(input gpr_variant_t v);
    gpr_pa_pin_mask = (v == GPR_PINS_28) ? PA_PIN_FULL : (PA_PIN_FULL & ~PA_BIT7);
  endfunction

  function automatic logic [15:0] gpr_pb_mask(input gpr_variant_t v);
    case (v)
      GPR_PINS_14: gpr_pb_mask = ~(PB_MISSING_SMALL | PB_MISSING_14);
      GPR_PINS_20: gpr_pb_mask = ~PB_MISSING_SMALL;
      default:     gpr_pb_mask = 16'hffff;
    endcase
  endfunction

  function automatic logic [15:0] gpr_pad_mask(input logic spi2_present);
    gpr_pad_mask = spi2_present ? PAD_MASK_FULL : PAD_MASK_SMALL;
  endfunction

endpackage

// *** logic/gpr_top.sv ***
// gpr_top: port A, port B and pad configuration registers with pin drive logic
`timescale 1ns/1ps
module gpr_top #(
  parameter gpr_pkg::gpr_variant_t VARIANT      = gpr_pkg::GPR_PINS_28,
  parameter bit                    SPI2_PRESENT = 1'b1
) (
  input  wire logic [gpr_pkg::ADDR_W-1:0]  addr,
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [gpr_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [gpr_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                        reset_pin_enable_fuse,
  input  wire logic [gpr_pkg::PA_PINS-1:0] pa_in,
  output logic      [gpr_pkg::PA_PINS-1:0] pa_out,
  output logic      [gpr_pkg::PA_PINS-1:0] pa_oe,
  input  wire logic [gpr_pkg::PB_PINS-1:0] pb_in,
  output logic      [gpr_pkg::PB_PINS-1:0] pb_out,
  output logic      [gpr_pkg::PB_PINS-1:0] pb_oe,
  output logic                             spi1_data_out_disable,
  output logic                             spi1_clock_out_disable,
  output logic                             spi2_data_out_disable,
  output logic                             spi2_clock_out_disable
);
  import gpr_pkg::*;

  localparam logic [15:0] PA_MASK     = gpr_pa_dir_mask(VARIANT);
  localparam logic [15:0] PA_PIN_MASK = gpr_pa_pin_mask(VARIANT);
  localparam logic [15:0] PB_MASK     = gpr_pb_mask(VARIANT);
  localparam logic [15:0] PAD_MASK    = gpr_pad_mask(SPI2_PRESENT);

  gpr_reg_t    sel;
  logic [15:0] pa_dir_q;
  logic [15:0] pa_dir_d;
  logic [15:0] pa_lat_q;
  logic [15:0] pa_lat_d;
  logic [15:0] pa_odc_q;
  logic [15:0] pa_odc_d;
  logic [15:0] pb_dir_q;
  logic [15:0] pb_dir_d;
  logic [15:0] pb_lat_q;
  logic [15:0] pb_lat_d;
  logic [15:0] pb_odc_q;
  logic [15:0] pb_odc_d;
  logic [15:0] pad_q;
  logic [15:0] pad_d;
  logic [15:0] rd_data_q;
  logic [15:0] rd_data_d;
  logic [23:0] pins_sync;
  logic [15:0] pa_pin_view;
  logic [15:0] pb_pin_view;
  logic [15:0] pa_fuse_mask;

  assign sel = gpr_decode(addr);

  // pins are asynchronous to clk, so they pass the three-stage synchroniser
  gpr_pin_sync #(
    .WIDTH (24)
  ) u_pin_sync (
    .clk      (clk),
    .srst     (srst),
    .pin_in   ({pb_in, pa_in}),
    .pin_sync (pins_sync)
  );

  // the fuse hands bit 5 to the reset pin, so the port loses it entirely
  assign pa_fuse_mask = reset_pin_enable_fuse ? ~PA_RST_PIN_BIT : 16'hffff;
  assign pa_pin_view  = {8'h00, pins_sync[7:0]} & PA_PIN_MASK & pa_fuse_mask;
  assign pb_pin_view  = pins_sync[23:8] & PB_MASK;

  // next values: writes are masked, so absent bits never store a one
  always_comb
  begin
    pa_dir_d = pa_dir_q;
    pa_odc_d = pa_odc_q;
    pb_dir_d = pb_dir_q;
    pb_odc_d = pb_odc_q;
    pad_d    = pad_q;
    pa_lat_d = pa_lat_q;
    pb_lat_d = pb_lat_q;
    if (wr_en)
    begin
      case (sel)
        GPR_SEL_PA_DIR: pa_dir_d = wr_data & PA_MASK;
        GPR_SEL_PA_PIN: pa_lat_d = wr_data & PA_MASK;
        GPR_SEL_PA_LAT: pa_lat_d = wr_data & PA_MASK;
        GPR_SEL_PA_ODC: pa_odc_d = wr_data & PA_MASK;
        GPR_SEL_PB_DIR: pb_dir_d = wr_data & PB_MASK;
        GPR_SEL_PB_PIN: pb_lat_d = wr_data & PB_MASK;
        GPR_SEL_PB_LAT: pb_lat_d = wr_data & PB_MASK;
        GPR_SEL_PB_ODC: pb_odc_d = wr_data & PB_MASK;
        GPR_SEL_PAD:    pad_d    = wr_data & PAD_MASK;
        default:        pad_d    = pad_q;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pa_dir_q <= RST_PA_DIR & PA_MASK;
      pb_dir_q <= RST_PB_DIR & PB_MASK;
      pa_odc_q <= RST_ODC;
      pb_odc_q <= RST_ODC;
      pad_q    <= RST_PAD;
    end
    else
    begin
      pa_dir_q <= pa_dir_d;
      pb_dir_q <= pb_dir_d;
      pa_odc_q <= pa_odc_d;
      pb_odc_q <= pb_odc_d;
      pad_q    <= pad_d;
    end
  end

  // latches keep no reset; direction resets to input so the unknown never reaches a pin
  always_ff @(posedge clk)
  begin
    pa_lat_q <= pa_lat_d;
    pb_lat_q <= pb_lat_d;
  end

  // read data stands only in the cycle after the read strobe
  // latch bits without a pin are masked, so a never written latch still reads zero there
  always_comb
  begin
    rd_data_d = 16'h0000;
    if (rd_en)
    begin
      case (sel)
        GPR_SEL_PA_DIR: rd_data_d = pa_dir_q;
        GPR_SEL_PA_PIN: rd_data_d = pa_pin_view;
        GPR_SEL_PA_LAT: rd_data_d = pa_lat_q & PA_MASK;
        GPR_SEL_PA_ODC: rd_data_d = pa_odc_q;
        GPR_SEL_PB_DIR: rd_data_d = pb_dir_q;
        GPR_SEL_PB_PIN: rd_data_d = pb_pin_view;
        GPR_SEL_PB_LAT: rd_data_d = pb_lat_q & PB_MASK;
        GPR_SEL_PB_ODC: rd_data_d = pb_odc_q;
        GPR_SEL_PAD:    rd_data_d = pad_q;
        default:        rd_data_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_data_q <= 16'h0000;
    end
    else
    begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

  // open drain keeps the driver off whenever the latch asks for high
  assign pa_oe  = (~pa_dir_q[7:0]) & (~pa_odc_q[7:0] | ~pa_lat_q[7:0]) & PA_MASK[7:0];
  assign pa_out = pa_lat_q[7:0] & (~pa_odc_q[7:0]) & (~pa_dir_q[7:0]) & PA_MASK[7:0];
  assign pb_oe  = (~pb_dir_q) & (~pb_odc_q | ~pb_lat_q) & PB_MASK;
  assign pb_out = pb_lat_q & (~pb_odc_q) & (~pb_dir_q) & PB_MASK;

  assign spi1_clock_out_disable = pad_q[PAD_SCK1_POS];
  assign spi1_data_out_disable  = pad_q[PAD_SDO1_POS];
  assign spi2_clock_out_disable = pad_q[PAD_SCK2_POS];
  assign spi2_data_out_disable  = pad_q[PAD_SDO2_POS];

  // checks

  sequence s_write_pa_dir;
    wr_en && (addr == OFS_PA_DIR);
  endsequence

  sequence s_read_pa_dir;
    rd_en && !wr_en && (addr == OFS_PA_DIR);
  endsequence

  sequence s_write_pad;
    wr_en && (addr == OFS_PAD);
  endsequence

  sequence s_read_pad;
    rd_en && !wr_en && (addr == OFS_PAD);
  endsequence

  sequence s_write_pb_lat;
    wr_en && (addr == OFS_PB_LAT);
  endsequence

  unmapped_read_zero_a: assert property (@(posedge clk) disable iff (srst)
    (rd_en && (gpr_decode(addr) == GPR_SEL_NONE)) |=> (rd_data == 16'h0000))
    else $error("unmapped read did not return zero");

  fuse_hides_a5_a: assert property (@(posedge clk) disable iff (srst)
    (rd_en && (addr == OFS_PA_PIN) && reset_pin_enable_fuse) |=> (rd_data[5] == 1'b0))
    else $error("port A bit 5 visible while reset pin fuse set");

  pa_absent_bits_a: assert property (@(posedge clk) disable iff (srst)
    ((pa_dir_q | pa_odc_q) & ~PA_MASK) == 16'h0000)
    else $error("absent port A bit holds a one");

  pb_absent_bits_a: assert property (@(posedge clk) disable iff (srst)
    (((pb_dir_q | pb_odc_q) & ~PB_MASK) == 16'h0000) && ((pb_oe & ~PB_MASK) == 16'h0000))
    else $error("absent port B bit holds a one or drives");

  pa_dir_reset_a: assert property (@(posedge clk)
    srst |=> (pa_dir_q == (RST_PA_DIR & PA_MASK)) && (pa_oe == 8'h00))
    else $error("port A direction wrong after reset");

  pb_dir_reset_a: assert property (@(posedge clk)
    srst |=> (pb_dir_q == (RST_PB_DIR & PB_MASK)) && (pb_oe == 16'h0000))
    else $error("port B direction wrong after reset");

  odc_reset_a: assert property (@(posedge clk)
    srst |=> (pa_odc_q == RST_ODC) && (pb_odc_q == RST_ODC))
    else $error("open drain registers not cleared by reset");

  pad_reset_a: assert property (@(posedge clk)
    srst |=> (pad_q == RST_PAD) && !spi1_data_out_disable && !spi2_clock_out_disable)
    else $error("pad configuration not cleared by reset");

  pad_readback_a: assert property (@(posedge clk) disable iff (srst)
    s_write_pad ##1 s_read_pad |=> (rd_data == ($past(wr_data, 2) & PAD_MASK)))
    else $error("pad configuration read back wrong");

  pa_dir_readback_a: assert property (@(posedge clk) disable iff (srst)
    s_write_pa_dir ##1 s_read_pa_dir |=> (rd_data == ($past(wr_data, 2) & PA_MASK)))
    else $error("port A direction read back wrong");

  input_not_driven_a: assert property (@(posedge clk) disable iff (srst)
    ((pb_oe & pb_dir_q) == 16'h0000) && ((pa_oe & pa_dir_q[7:0]) == 8'h00))
    else $error("pin set as input is driven");

  open_drain_low_a: assert property (@(posedge clk) disable iff (srst)
    ((pb_out & pb_odc_q) == 16'h0000) && ((pb_oe & pb_odc_q & pb_lat_q) == 16'h0000))
    else $error("open drain pin driven high");

  latch_drives_pin_a: assert property (@(posedge clk) disable iff (srst)
    s_write_pb_lat |=> (pb_out == ($past(wr_data) & PB_MASK & ~pb_odc_q & ~pb_dir_q)))
    else $error("port B output does not follow latch");

  // write checks compare against the bus word under the same mask localparam, so a wrong select shows up but a wrong mask does not
  rd_idle_zero_a: assert property (@(posedge clk) disable iff (srst)
    !rd_en |=> (rd_data == 16'h0000))
    else $error("read data not zero outside a read");

  lat_read_masked_a: assert property (@(posedge clk) disable iff (srst)
    (rd_en && (addr == OFS_PA_LAT)) |=> ((rd_data & ~PA_MASK) == 16'h0000))
    else $error("absent port A latch bit reads non zero");

  pa_open_drain_a: assert property (@(posedge clk) disable iff (srst)
    ((pa_out & pa_odc_q[7:0]) == 8'h00) && ((pa_oe & pa_odc_q[7:0] & pa_lat_q[7:0]) == 8'h00))
    else $error("port A open drain pin driven high");

  fuse_pin_undriven_a: assert property (@(posedge clk) disable iff (srst)
    reset_pin_enable_fuse |-> ((pa_oe & PA_RST_PIN_BIT[7:0]) == 8'h00))
    else $error("port A bit 5 driven while reset pin fuse set");

  pad_absent_bits_a: assert property (@(posedge clk) disable iff (srst)
    (pad_q & ~PAD_MASK) == 16'h0000)
    else $error("absent pad configuration bit holds a one");

  spi_disable_map_a: assert property (@(posedge clk) disable iff (srst)
    s_write_pad |=> ({spi2_data_out_disable, spi2_clock_out_disable, spi1_data_out_disable,
      spi1_clock_out_disable} == ($past(wr_data[11:8]) & PAD_MASK[11:8])))
    else $error("spi disable outputs do not follow pad write");

  pb_dir_write_a: assert property (@(posedge clk) disable iff (srst)
    (wr_en && (addr == OFS_PB_DIR)) |=> (pb_dir_q == ($past(wr_data) & PB_MASK)))
    else $error("port B direction write not masked");

  pa_odc_write_a: assert property (@(posedge clk) disable iff (srst)
    (wr_en && (addr == OFS_PA_ODC)) |=> (pa_odc_q == ($past(wr_data) & PA_MASK)))
    else $error("port A open drain write not masked");

  pa_pin_write_a: assert property (@(posedge clk) disable iff (srst)
    (wr_en && (addr == OFS_PA_PIN)) |=> (pa_lat_q == ($past(wr_data) & PA_MASK)))
    else $error("port A pin value write did not reach latch");

  pb_pin_write_a: assert property (@(posedge clk) disable iff (srst)
    (wr_en && (addr == OFS_PB_PIN)) |=> (pb_lat_q == ($past(wr_data) & PB_MASK)))
    else $error("port B pin value write did not reach latch");

endmodule
